/* logic/timer16_core.sv */
/*
 * 16-bit timer/counter with clock select, prescaler, two compare channels,
 * input capture, byte registers with shared high-byte latch, AXI4-Lite slave.
 * assumes one 10 MHz clock, synchronous active-low reset, pins synchronous to ref_clk.
 */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns

// Functional notes
// - clock select zero gives no ticks; counter holds its value
// - codes 1..5 select clock undivided or divided by 8, 64, 256, 1024
// - code 6 counts on each falling edge of the external count pin
// - code 7 counts on each rising edge of the external count pin
// - force strobes act only in non-PWM waveform modes
// - force strobe applies the channel output action immediately
// - forced match raises no flag and never clears the counter
// - force bits are write strobes and always read zero
// - low byte at base index, high byte at base index plus one
// - one shared high-byte latch makes 16-bit accesses atomic
// - counter readable, writable; a write blocks matches on next tick
// - capture register loads counter on each capture event, pin or comparator
// - capture register can serve as top in modes selecting it
// - both compare registers compared continuously; match flags and drives output
// - capture input ignored while capture register is top
module timer16_core (
    input  wire logic                            ref_clk,
    input  wire logic                            reset_n,
    input  wire logic [timer16_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [timer16_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [timer16_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [timer16_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire logic                            ext_count_pin,
    input  wire logic                            capture_pin,
    input  wire logic                            comparator_out,
    output logic                                 wave_out_a,
    output logic                                 wave_out_b,
    output logic                                 irq
);
    import timer16_pkg::*;

    ctrl_t                  ctrl;
    logic [15:0]            counter_value;
    logic [15:0]            capture_value;
    logic [15:0]            compare_a_value;
    logic [15:0]            compare_b_value;
    logic [7:0]             high_latch;
    logic [7:0]             status;
    logic [7:0]             mask;
    logic [7:0]             next_status;
    count_dir_t             dir;
    logic [PRESC_W-1:0]     presc;
    logic                   ext_now;
    logic                   ext_prev;
    logic                   cap_now;
    logic                   cap_prev;
    logic                   match_block;
    logic [ADDR_W-1:0]      wr_addr;
    logic [DATA_W-1:0]      wr_data;
    logic                   wr_lane0;
    logic                   wr_go;
    logic                   rd_go;
    logic [7:0]             wr_idx;
    logic [7:0]             rd_idx;
    logic                   wr_ok;
    logic                   rd_ok;
    logic                   tick;
    logic                   is_pwm;
    logic                   dual_slope;
    logic                   capture_is_top;
    logic                   clears_on_top;
    logic                   toggle_a_ok;
    logic [15:0]            top;
    logic                   counter_wr;
    logic                   match_a;
    logic                   match_b;
    logic                   at_bottom;
    logic                   ev_overflow;
    logic                   ev_capture;
    logic                   force_a;
    logic                   force_b;
    logic [DATA_W-1:0]      rd_data;

    // index decode: any address outside the map is unmapped
    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        mapped = (addr[ADDR_W-1:10] == '0) && (addr[1:0] == 2'b00) &&
                 ((idx == IDX_CONTROL) || (idx == IDX_FORCE) ||
                  (idx >= IDX_COUNTER_LO && idx <= IDX_MASK));
    endfunction : mapped

    // output action on a match or a force in non-PWM modes
    function automatic logic act_plain(input logic [1:0] act, input logic cur);
        case (act)
            ACT_TOGGLE: act_plain = ~cur;
            ACT_CLEAR:  act_plain = 1'b0;
            ACT_SET:    act_plain = 1'b1;
            default:    act_plain = cur;
        endcase
    endfunction : act_plain

    // waveform output update for one channel per tick
    function automatic logic wave_step(input logic [1:0] act, input logic match,
                                       input logic bottom, input logic tog_ok,
                                       input logic cur, input logic pwm,
                                       input logic dual, input logic down);
        wave_step = cur;
        if (!pwm) begin
            if (match) wave_step = act_plain(act, cur);
        end else if (act == ACT_TOGGLE) begin
            if (match && tog_ok) wave_step = ~cur;
        end else if (act != ACT_NONE) begin
            if (match) wave_step = (act == ACT_SET) ^ (dual && down);
            else if (bottom && !dual) wave_step = (act == ACT_CLEAR);
        end
    endfunction : wave_step

    // waveform mode decode
    always_comb begin
        top = TOP_MAX;
        case (ctrl.waveform_mode)
            4'd1, 4'd5:                top = TOP_8BIT;
            4'd2, 4'd6:                top = TOP_9BIT;
            4'd3, 4'd7:                top = TOP_10BIT;
            4'd4, 4'd9, 4'd11, 4'd15:  top = compare_a_value;
            4'd8, 4'd10, 4'd12, 4'd14: top = capture_value;
            default:                   top = TOP_MAX;
        endcase
    end

    assign is_pwm         = !(ctrl.waveform_mode inside {4'd0, 4'd4, 4'd12});
    assign dual_slope     = ctrl.waveform_mode inside {4'd1, 4'd2, 4'd3, 4'd8,
                                                       4'd9, 4'd10, 4'd11};
    assign capture_is_top = ctrl.waveform_mode inside {4'd8, 4'd10, 4'd12, 4'd14};
    assign clears_on_top  = ctrl.waveform_mode inside {4'd4, 4'd12};
    assign toggle_a_ok    = ctrl.waveform_mode inside {4'd9, 4'd11, 4'd15};

    // bus strobes
    assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign rd_go  = s_axi_arvalid && s_axi_arready;
    assign wr_idx = wr_addr[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign wr_ok  = wr_go && wr_lane0 && mapped(wr_addr);
    assign rd_ok  = rd_go && mapped(s_axi_araddr);

    assign counter_wr = wr_ok && (wr_idx == IDX_COUNTER_LO);
    assign force_a = wr_ok && (wr_idx == IDX_FORCE) && wr_data[FORCE_A_BIT] && !is_pwm;
    assign force_b = wr_ok && (wr_idx == IDX_FORCE) && wr_data[FORCE_B_BIT] && !is_pwm;

    // clock source select
    always_comb begin
        case (ctrl.clk_sel)
            CLK_STOP:     tick = 1'b0;
            CLK_DIV1:     tick = 1'b1;
            CLK_DIV8:     tick = (presc & TAP_DIV8) == TAP_DIV8;
            CLK_DIV64:    tick = (presc & TAP_DIV64) == TAP_DIV64;
            CLK_DIV256:   tick = (presc & TAP_DIV256) == TAP_DIV256;
            CLK_DIV1024:  tick = (presc & TAP_DIV1024) == TAP_DIV1024;
            CLK_EXT_FALL: tick = ext_prev && !ext_now;
            CLK_EXT_RISE: tick = !ext_prev && ext_now;
            default:      tick = 1'b0;
        endcase
    end

    // compare and overflow events; a counter write masks the next tick's match
    assign match_a   = tick && !counter_wr && !match_block &&
                       (counter_value == compare_a_value);
    assign match_b   = tick && !counter_wr && !match_block &&
                       (counter_value == compare_b_value);
    assign at_bottom = tick && !counter_wr && !dual_slope && (counter_value == top);
    always_comb begin
        if (!tick || counter_wr)
            ev_overflow = 1'b0;
        else if (dual_slope)
            ev_overflow = (dir == DIR_DOWN) && (counter_value == '0);
        else if (is_pwm)
            ev_overflow = counter_value == top;
        else
            ev_overflow = counter_value == TOP_MAX;
    end

    // capture event from pin or comparator, disconnected while capture is top
    assign ev_capture = capture_is_top
                      ? (tick && !counter_wr && counter_value == top)
                      : ((cap_now != cap_prev) && (cap_now == ctrl.capture_rising));

    // free-running prescaler
    always_ff @(posedge ref_clk) begin
        if (!reset_n) presc <= '0;
        else          presc <= presc + 10'h001;
    end

    // pin sampling for edge detection
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ext_now  <= 1'b0;
            ext_prev <= 1'b0;
            cap_now  <= 1'b0;
            cap_prev <= 1'b0;
        end else begin
            ext_now  <= ext_count_pin;
            ext_prev <= ext_now;
            cap_now  <= ctrl.capture_from_comp ? comparator_out : capture_pin;
            cap_prev <= cap_now;
        end
    end

    // counter and direction
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            counter_value <= RESET_16;
            dir           <= DIR_UP;
        end else if (counter_wr) begin
            counter_value <= {high_latch, wr_data[7:0]};
        end else if (tick) begin
            case (dir)
                DIR_UP: begin
                    if (dual_slope && counter_value >= top) begin
                        dir           <= DIR_DOWN;
                        counter_value <= counter_value - 16'h0001;
                    end else if (!dual_slope && counter_value == top) begin
                        counter_value <= '0;
                    end else begin
                        counter_value <= counter_value + 16'h0001;
                    end
                end
                DIR_DOWN: begin
                    if (!dual_slope || counter_value == '0) begin
                        dir           <= DIR_UP;
                        counter_value <= counter_value + 16'h0001;
                    end else begin
                        counter_value <= counter_value - 16'h0001;
                    end
                end
                default: dir <= DIR_UP;
            endcase
        end
    end

    // match suppression after a counter write, held until the next tick
    always_ff @(posedge ref_clk) begin
        if (!reset_n)        match_block <= 1'b0;
        else if (counter_wr) match_block <= 1'b1;
        else if (tick)       match_block <= 1'b0;
    end

    // capture register: bus write or capture event
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            capture_value <= RESET_16;
        else if (wr_ok && wr_idx == IDX_CAPTURE_LO)
            capture_value <= {high_latch, wr_data[7:0]};
        else if (ev_capture && !capture_is_top)
            capture_value <= counter_value;
    end

    // compare registers, written atomically through the latch
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            compare_a_value <= RESET_16;
            compare_b_value <= RESET_16;
        end else if (wr_ok) begin
            if (wr_idx == IDX_CMP_A_LO) compare_a_value <= {high_latch, wr_data[7:0]};
            if (wr_idx == IDX_CMP_B_LO) compare_b_value <= {high_latch, wr_data[7:0]};
        end
    end

    // shared high-byte latch: high writes fill it, low reads of counter/capture load it
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            high_latch <= RESET_8;
        end else begin
            if (rd_ok && rd_idx == IDX_COUNTER_LO) high_latch <= counter_value[15:8];
            if (rd_ok && rd_idx == IDX_CAPTURE_LO) high_latch <= capture_value[15:8];
            if (wr_ok && wr_idx inside {IDX_COUNTER_HI, IDX_CAPTURE_HI,
                                        IDX_CMP_A_HI, IDX_CMP_B_HI})
                high_latch <= wr_data[7:0];
        end
    end

    // control and mask registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl <= RESET_CTRL;
            mask <= RESET_8;
        end else if (wr_ok) begin
            if (wr_idx == IDX_CONTROL) ctrl <= wr_data[CTRL_W-1:0];
            if (wr_idx == IDX_MASK)    mask <= wr_data[7:0];
        end
    end

    // sticky status: a read clears, a new event in the same cycle wins
    always_comb begin
        next_status = status;
        if (rd_ok && rd_idx == IDX_STATUS) next_status = '0;
        next_status[ST_OVERFLOW] = next_status[ST_OVERFLOW] | ev_overflow;
        next_status[ST_MATCH_A]  = next_status[ST_MATCH_A] | match_a;
        next_status[ST_MATCH_B]  = next_status[ST_MATCH_B] | match_b;
        next_status[ST_CAPTURE]  = next_status[ST_CAPTURE] | ev_capture;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status <= RESET_8;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & mask);
        end
    end

    // waveform outputs; forced matches act here only, never on flags or counter
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end else begin
            if (force_a)
                wave_out_a <= act_plain(ctrl.action_a, wave_out_a);
            else
                wave_out_a <= wave_step(ctrl.action_a, match_a, at_bottom, toggle_a_ok,
                                        wave_out_a, is_pwm, dual_slope, dir == DIR_DOWN);
            if (force_b)
                wave_out_b <= act_plain(ctrl.action_b, wave_out_b);
            else
                wave_out_b <= wave_step(ctrl.action_b, match_b, at_bottom, 1'b0,
                                        wave_out_b, is_pwm, dual_slope, dir == DIR_DOWN);
        end
    end

    // read data mux, one byte per index except the 13-bit control word
    always_comb begin
        rd_data = '0;
        case (rd_idx)
            IDX_CONTROL:    rd_data[CTRL_W-1:0] = ctrl;
            IDX_FORCE:      rd_data = '0;
            IDX_COUNTER_LO: rd_data[7:0] = counter_value[7:0];
            IDX_COUNTER_HI: rd_data[7:0] = high_latch;
            IDX_CAPTURE_LO: rd_data[7:0] = capture_value[7:0];
            IDX_CAPTURE_HI: rd_data[7:0] = high_latch;
            IDX_CMP_A_LO:   rd_data[7:0] = compare_a_value[7:0];
            IDX_CMP_A_HI:   rd_data[7:0] = compare_a_value[15:8];
            IDX_CMP_B_LO:   rd_data[7:0] = compare_b_value[7:0];
            IDX_CMP_B_HI:   rd_data[7:0] = compare_b_value[15:8];
            IDX_STATUS:     rd_data[7:0] = status;
            IDX_MASK:       rd_data[7:0] = mask;
            default:        rd_data = '0;
        endcase
    end

    // write channels: take address and data in either order, then respond
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_lane0      <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data      <= s_axi_wdata;
                wr_lane0     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channels: data registered one cycle after the address is taken
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= mapped(s_axi_araddr) ? rd_data : '0;
            s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : timer16_core

/* logic/timer16_pkg.sv */
/*
 * constants, types and register map of the 16-bit timer/counter block.
 * assumes a 32-bit AXI4-Lite master; each byte register sits at byte address index*4.
 */
package timer16_pkg;

    // bus geometry
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    // register indices, byte address is index * 4
    localparam logic [7:0]  IDX_CONTROL     = 8'h80;
    localparam logic [7:0]  IDX_FORCE       = 8'h82;
    localparam logic [7:0]  IDX_COUNTER_LO  = 8'h84;
    localparam logic [7:0]  IDX_COUNTER_HI  = 8'h85;
    localparam logic [7:0]  IDX_CAPTURE_LO  = 8'h86;
    localparam logic [7:0]  IDX_CAPTURE_HI  = 8'h87;
    localparam logic [7:0]  IDX_CMP_A_LO    = 8'h88;
    localparam logic [7:0]  IDX_CMP_A_HI    = 8'h89;
    localparam logic [7:0]  IDX_CMP_B_LO    = 8'h8a;
    localparam logic [7:0]  IDX_CMP_B_HI    = 8'h8b;
    localparam logic [7:0]  IDX_STATUS      = 8'h8c;
    localparam logic [7:0]  IDX_MASK        = 8'h8d;

    // reset values
    localparam logic [15:0] RESET_16        = 16'h0000;
    localparam logic [7:0]  RESET_8         = 8'h00;

    // force strobe bit positions
    localparam int          FORCE_A_BIT     = 7;
    localparam int          FORCE_B_BIT     = 6;

    // status and mask bit positions
    localparam int          ST_OVERFLOW     = 0;
    localparam int          ST_MATCH_A      = 1;
    localparam int          ST_MATCH_B      = 2;
    localparam int          ST_CAPTURE      = 5;

    // clock source codes
    localparam logic [2:0]  CLK_STOP        = 3'h0;
    localparam logic [2:0]  CLK_DIV1        = 3'h1;
    localparam logic [2:0]  CLK_DIV8        = 3'h2;
    localparam logic [2:0]  CLK_DIV64       = 3'h3;
    localparam logic [2:0]  CLK_DIV256      = 3'h4;
    localparam logic [2:0]  CLK_DIV1024     = 3'h5;
    localparam logic [2:0]  CLK_EXT_FALL    = 3'h6;
    localparam logic [2:0]  CLK_EXT_RISE    = 3'h7;

    // prescaler taps: a tick when the masked low bits are all ones
    localparam int          PRESC_W         = 10;
    localparam logic [9:0]  TAP_DIV8        = 10'h007;
    localparam logic [9:0]  TAP_DIV64       = 10'h03f;
    localparam logic [9:0]  TAP_DIV256      = 10'h0ff;
    localparam logic [9:0]  TAP_DIV1024     = 10'h3ff;

    // fixed top values
    localparam logic [15:0] TOP_MAX         = 16'hffff;
    localparam logic [15:0] TOP_8BIT        = 16'h00ff;
    localparam logic [15:0] TOP_9BIT        = 16'h01ff;
    localparam logic [15:0] TOP_10BIT       = 16'h03ff;

    // output action codes
    localparam logic [1:0]  ACT_NONE        = 2'b00;
    localparam logic [1:0]  ACT_TOGGLE      = 2'b01;
    localparam logic [1:0]  ACT_CLEAR       = 2'b10;
    localparam logic [1:0]  ACT_SET         = 2'b11;

    // control register layout, high bits first in the word
    typedef struct packed {
        logic       capture_from_comp;
        logic       capture_rising;
        logic [1:0] action_b;
        logic [1:0] action_a;
        logic [3:0] waveform_mode;
        logic [2:0] clk_sel;
    } ctrl_t;

    localparam int          CTRL_W          = $bits(ctrl_t);
    localparam logic [12:0] RESET_CTRL      = 13'h0000;

    // counting direction of dual-slope modes
    typedef enum logic [0:0] {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_t;

endpackage : timer16_pkg

/* verif/timer16_core_properties.sv */
/* port checker for timer16_core
   assumes binding onto timer16_core from the bench */
`timescale 1ns/1ns
module timer16_checker (
    input wire logic ref_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq,
    input wire logic [timer16_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [timer16_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]                     s_axi_rresp
);
    import timer16_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // handshake helpers
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    a_read_answer: assert property (ar_hs |=> s_axi_rvalid) else $error("no read answer");
    a_write_answer: assert property (aw_hs |-> ##2 s_axi_bvalid) else $error("no write answer");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_force_reads_zero: assert property (ar_hs && s_axi_araddr == 12'({IDX_FORCE, 2'b00})
        |=> s_axi_rdata == 32'h0) else $error("force strobe read nonzero");
    a_unmapped_error: assert property (ar_hs && s_axi_araddr == 12'h000
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read ok");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("awready early");
    // main scenarios
    c_read: cover property (ar_hs);
    c_write: cover property (aw_hs);
    c_irq: cover property ($rose(irq));
endmodule : timer16_checker

/* verif/timer16_core_tb.sv */
/* self-checking bench for timer16_core over AXI4-Lite
   assumes the checker file is compiled before this one */
`timescale 1ns/1ns
module timer16_core_tb;
    import timer16_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_count_pin = 1'b0;
    logic capture_pin = 1'b0, comparator_out = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, wave_out_a, wave_out_b, irq;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
    logic [15:0]       v0, v1;
    logic [7:0]        rv;
    int                n_fail = 0, n_tests = 0, i;
    int                dv[6] = '{1, 1, 8, 64, 256, 1024};
    timer16_core timer16_core_inst (.*);
    always #50 ref_clk = ~ref_clk;
    // verdict and end of run
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // bounded wait result
    task late;
        if (i >= 60) begin
            n_fail++;
            finish_test();
        end
    endtask : late
    task wr(input logic [7:0] idx, input logic [15:0] d);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        i = 0;
        do @(posedge ref_clk); while (!(s_axi_awready && s_axi_wready) && ++i < 60);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_bvalid && ++i < 60);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        late();
    endtask : wr
    task rd(input logic [7:0] idx, output logic [7:0] d);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        i = 0;
        do @(posedge ref_clk); while (!s_axi_arready && ++i < 60);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid && ++i < 60);
        d = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        late();
    endtask : rd
    // 16-bit pairs: high byte through the shared latch
    task rd16(input logic [7:0] idx, output logic [15:0] v);
        rd(idx, v[7:0]);
        rd(idx + 8'h01, v[15:8]);
    endtask : rd16
    task wr16(input logic [7:0] idx, input logic [15:0] v);
        wr(idx + 8'h01, {8'h00, v[15:8]});
        wr(idx, {8'h00, v[7:0]});
    endtask : wr16
    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd16(IDX_CMP_B_LO, v0);
        chk(v0, RESET_16, "compare b reset");
        rd(8'h00, rv);
        chk({resp, rv}, {RESP_SLVERR, 8'h00}, "unmapped read");
        wr(8'h00, 16'h0000);
        chk(resp, RESP_SLVERR, "unmapped write");
        wr16(IDX_CMP_A_LO, 16'h1234);
        rd16(IDX_CMP_A_LO, v0);
        chk(v0, 16'h1234, "compare a pair");
        $display("test registers done");
        // each internal clock code, 0 to 5, over eight prescaled periods
        for (int c = 0; c < 6; c++) begin
            wr(IDX_CONTROL, 16'(c));
            rd16(IDX_COUNTER_LO, v0);
            repeat (8 * dv[c] - 4) @(posedge ref_clk);
            rd16(IDX_COUNTER_LO, v1);
            chk(v1 - v0, (c == 0) ? 16'd0 : 16'd8, "ticks per code");
        end
        // nine pin toggles: five edges of the counted kind
        for (int c = 7; c > 5; c--) begin
            wr(IDX_CONTROL, 16'(c));
            rd16(IDX_COUNTER_LO, v0);
            repeat (9) begin
                ext_count_pin <= ~ext_count_pin;
                repeat (3) @(posedge ref_clk);
            end
            rd16(IDX_COUNTER_LO, v1);
            chk(v1 - v0, 16'd5, "external edges");
        end
        $display("test clock select done");
        wr(IDX_CONTROL, 16'h0080);
        rd(IDX_STATUS, rv);
        wr(IDX_FORCE, 16'h00c0);
        chk(wave_out_a, 1'b1, "forced toggle");
        chk(wave_out_b, 1'b0, "force b no action");
        rd(IDX_FORCE, rv);
        chk(rv, 8'h00, "force readback");
        rd(IDX_STATUS, rv);
        chk(rv, 8'h00, "forced flags");
        wr(IDX_CONTROL, 16'h00f8);
        wr(IDX_FORCE, 16'h00c0);
        chk(wave_out_a, 1'b1, "force in pwm");
        $display("test force done");
        // b at zero is skipped on the first tick after the counter write
        wr16(IDX_COUNTER_LO, 16'h0000);
        wr16(IDX_CMP_A_LO, 16'h0040);
        wr16(IDX_CMP_B_LO, 16'h0000);
        wr(IDX_MASK, 16'h0002);
        wr(IDX_CONTROL, 16'h0001);
        repeat (100) @(posedge ref_clk);
        chk(irq, 1'b1, "match irq");
        rd(IDX_STATUS, rv);
        chk(rv, 8'h02, "match flags");
        chk(irq, 1'b0, "irq after clear");
        wr(IDX_CONTROL, 16'h0800);
        wr16(IDX_COUNTER_LO, 16'h0abc);
        capture_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd16(IDX_CAPTURE_LO, v0);
        chk(v0, 16'h0abc, "capture value");
        $display("test irq and capture done");
        finish_test();
    end
endmodule : timer16_core_tb
bind timer16_core timer16_checker timer16_checker_inst (.*);
